/* File: pkg/cmpset_pkg.sv */
/*
  Shared types and constants of the comparator setup command handler:
  command codes, setting encodings, value ranges and timing counts.
  Assumes resistances arrive in micro-ohms and percentages in units of 0.001 %.
*/
package cmpset_pkg;

  localparam int unsigned VAL_W      = 48;
  localparam int unsigned PCT_W      = 18;
  localparam int unsigned WIDTH_W    = 7;
  localparam int unsigned EOM_CNT_W  = 24;

  // 120.000E+6 ohm expressed in micro-ohm
  localparam logic [VAL_W-1:0] RES_MAX     = 48'h6d23_ad5f_8000;
  // 99.990 % and 10.00 % in steps of 0.001 %
  localparam logic signed [PCT_W-1:0] PCT_MAX    = 18'sh18696;
  localparam logic [PCT_W-1:0]        PCT_COARSE = 18'h02710;
  localparam logic [PCT_W-1:0]        PCT_STEP   = 18'h0000a;
  localparam logic [16:0]             PCT_SCALE  = 17'h186a0;

  // pulse width is carried in milliseconds
  localparam logic [WIDTH_W-1:0] WIDTH_MIN = 7'h01;
  localparam logic [WIDTH_W-1:0] WIDTH_MAX = 7'h64;
  localparam logic [WIDTH_W-1:0] WIDTH_RST = 7'h05;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_NONE, OP_COMP_EN, OP_BEEP, OP_MODE, OP_ABS, OP_REF, OP_PERC, OP_RESULT,
    OP_CAL, OP_CAL_AUTO, OP_PANEL_LOCK, OP_HEADER, OP_GEN_RESET, OP_DONE_MODE, OP_DONE_WIDTH
  } cmpset_op_t;

  typedef enum logic [2:0] {
    BEEP_OFF, BEEP_ABOVE, BEEP_IN, BEEP_BELOW, BEEP_ABOVE_OR_BELOW
  } cmpset_beep_t;

  typedef enum logic {MODE_ABS, MODE_REF} cmpset_mode_t;

  typedef enum logic [2:0] {
    RES_ABOVE, RES_IN, RES_BELOW, RES_ERR, RES_OFF
  } cmpset_res_t;

  typedef enum logic {DONE_HOLD, DONE_PULSE} cmpset_done_t;

  typedef struct packed {
    logic              valid;
    cmpset_op_t        op;
    logic              query;
    logic [VAL_W-1:0]  arg_a;
    logic [VAL_W-1:0]  arg_b;
  } cmpset_cmd_t;

  typedef struct packed {
    logic              valid;
    logic              err;
    cmpset_op_t        op;
    logic [VAL_W-1:0]  data_a;
    logic [VAL_W-1:0]  data_b;
  } cmpset_resp_t;

  typedef struct packed {
    logic              start;
    logic              done;
    logic              fault;
    logic [VAL_W-1:0]  value;
  } cmpset_meas_t;

  typedef struct packed {
    logic                     enable;
    cmpset_mode_t             mode;
    logic [VAL_W-1:0]         upper;
    logic [VAL_W-1:0]         lower;
    logic [VAL_W-1:0]         ref_val;
    logic signed [PCT_W-1:0]  pct_up;
    logic signed [PCT_W-1:0]  pct_lo;
  } cmpset_cfg_t;

endpackage : cmpset_pkg

/* File: logic/cmpset_judge.sv */
/*
  Pass/fail decision of one finished measurement against the held settings.
  Assumes the measurement done strobe is one cycle long and carries its value.
*/
`timescale 1ns/1ps
module cmpset_judge (
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire cmpset_pkg::cmpset_cfg_t  i_cfg,
  input  wire cmpset_pkg::cmpset_meas_t i_meas,
  output cmpset_pkg::cmpset_res_t   o_result
);

  typedef struct packed {
    cmpset_pkg::cmpset_res_t result;
  } cmpset_jst_t;

  cmpset_jst_t st;
  cmpset_jst_t next_st;

  logic signed [71:0] dev_scaled;
  logic signed [71:0] win_up;
  logic signed [71:0] win_lo;

  // deviation compared by cross-multiplication so no divider is needed
  always_comb begin
    dev_scaled = (72'(signed'({1'b0, i_meas.value})) - 72'(signed'({1'b0, i_cfg.ref_val})))
                 * 72'(signed'({1'b0, cmpset_pkg::PCT_SCALE}));
    win_up = 72'(i_cfg.pct_up) * 72'(signed'({1'b0, i_cfg.ref_val}));
    win_lo = 72'(i_cfg.pct_lo) * 72'(signed'({1'b0, i_cfg.ref_val}));
  end

  always_comb begin
    next_st = st;
    if (i_meas.done) begin
      if (!i_cfg.enable) begin
        next_st.result = cmpset_pkg::RES_OFF;
      end else if (i_meas.fault) begin
        next_st.result = cmpset_pkg::RES_ERR;
      end else if (i_cfg.mode == cmpset_pkg::MODE_ABS) begin
        if (i_meas.value > i_cfg.upper) begin
          next_st.result = cmpset_pkg::RES_ABOVE;
        end else if (i_meas.value < i_cfg.lower) begin
          next_st.result = cmpset_pkg::RES_BELOW;
        end else begin
          next_st.result = cmpset_pkg::RES_IN;
        end
      end else if (i_cfg.ref_val == '0) begin
        // a zero reference gives no defined percentage
        next_st.result = cmpset_pkg::RES_ERR;
      end else if (dev_scaled > win_up) begin
        next_st.result = cmpset_pkg::RES_ABOVE;
      end else if (dev_scaled < win_lo) begin
        next_st.result = cmpset_pkg::RES_BELOW;
      end else begin
        next_st.result = cmpset_pkg::RES_IN;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '{result: cmpset_pkg::RES_OFF};
    end else begin
      st <= next_st;
    end
  end

  assign o_result = st.result;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_off_result;
    i_meas.done && !i_cfg.enable |=> o_result == cmpset_pkg::RES_OFF;
  endproperty
  a_off_result: assert property (p_off_result) else $error("disabled comparator not reported off");

  property p_ref_inside;
    i_meas.done && i_cfg.enable && !i_meas.fault && i_cfg.mode == cmpset_pkg::MODE_REF
      && i_cfg.ref_val != '0 && dev_scaled <= win_up && dev_scaled >= win_lo
      |=> o_result == cmpset_pkg::RES_IN;
  endproperty
  a_ref_inside: assert property (p_ref_inside) else $error("deviation inside window not in");

  property p_abs_above;
    i_meas.done && i_cfg.enable && !i_meas.fault && i_cfg.mode == cmpset_pkg::MODE_ABS
      && i_meas.value > i_cfg.upper |=> o_result == cmpset_pkg::RES_ABOVE;
  endproperty
  a_abs_above: assert property (p_abs_above) else $error("value above upper not flagged");

  c_ref_judge: cover property (i_meas.done && i_cfg.enable && i_cfg.mode == cmpset_pkg::MODE_REF);

endmodule : cmpset_judge

/* File: logic/cmpset_handler.sv */
/*
  Remote command handler for comparator and system settings of a resistance meter,
  with end-of-measurement output and self-calibration scheduling.
  Assumes synchronous command, key and measurement strobes on i_clk, one cycle each.
*/
`timescale 1ns/1ps
// How it works
// - comparator setting writes never ask the measurement engine for a new range
// - beeper condition takes off, above, in, below or above-or-below; query returns it
// - absolute mode keeps upper and lower limits within 0 to 120E+6 ohm
// - limits read back upper then lower; out-of-range limit is rejected
// - reference resistance is held within 0 to 120E+6 ohm
// - both tolerance percentages accept -99.990 to 99.990 and read back as a pair
// - percentages of magnitude 10.00 or more are cut to 0.01 steps
// - decision mode picks absolute limits or reference with percentages
// - result query returns above, in, below, error or off
// - calibration asked during a measurement waits for its end
// - auto or manual calibration selectable; explicit command always calibrates
// - full panel lock makes every settings key be ignored
// - header flag is off after reset and after the general reset command
// - end-of-measurement output goes active when a measurement completes
// - hold mode releases it when the next measurement starts
// - pulse mode releases it after the programmed width
// - pulse width is programmable from 1 to 100 ms
module cmpset_handler #(
  parameter int unsigned P_CYC_PER_MS = cmpset_pkg::CYC_PER_MS
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire cmpset_pkg::cmpset_cmd_t   i_cmd,
  input  wire cmpset_pkg::cmpset_cmd_t   i_key,
  input  wire cmpset_pkg::cmpset_meas_t  i_meas,
  output logic                       o_cmd_ready,
  output cmpset_pkg::cmpset_resp_t   o_resp,
  output logic                       o_range_keep,
  output logic                       o_cal_start,
  output logic                       o_cal_auto,
  output logic                       o_panel_locked,
  output logic                       o_header_on,
  output cmpset_pkg::cmpset_beep_t   o_beep_sel,
  output cmpset_pkg::cmpset_cfg_t    o_cfg,
  output logic                       o_end_of_measurement_out
);

  typedef struct packed {
    cmpset_pkg::cmpset_cfg_t          cfg;
    cmpset_pkg::cmpset_beep_t         beep;
    logic                             cal_auto;
    logic                             panel_lock;
    logic                             header;
    cmpset_pkg::cmpset_done_t         done_mode;
    logic [cmpset_pkg::WIDTH_W-1:0]   done_width;
    logic                             measuring;
    logic                             cal_pend;
    logic                             cal_go;
    logic                             end_of_measurement_out;
    logic [cmpset_pkg::EOM_CNT_W-1:0] eom_cnt;
    logic                             range_keep;
    cmpset_pkg::cmpset_resp_t         resp;
  } cmpset_st_t;

  localparam cmpset_pkg::cmpset_cfg_t CFG_RST = '{
    enable:  1'b0,
    mode:    cmpset_pkg::MODE_ABS,
    upper:   '0,
    lower:   '0,
    ref_val: '0,
    pct_up:  '0,
    pct_lo:  '0
  };

  cmpset_st_t st;
  cmpset_st_t next_st;
  cmpset_pkg::cmpset_res_t result;
  cmpset_pkg::cmpset_cmd_t act;
  logic act_remote;

  // cut magnitudes of 10.00 % or more to the coarse step, sign kept
  function automatic logic signed [cmpset_pkg::PCT_W-1:0] pct_quant(
    input logic signed [cmpset_pkg::PCT_W-1:0] p
  );
    logic [cmpset_pkg::PCT_W-1:0] mag;
    mag = p[cmpset_pkg::PCT_W-1] ? cmpset_pkg::PCT_W'(-p) : cmpset_pkg::PCT_W'(p);
    if (mag >= cmpset_pkg::PCT_COARSE) begin
      mag = mag - (mag % cmpset_pkg::PCT_STEP);
    end
    pct_quant = p[cmpset_pkg::PCT_W-1] ? -signed'(mag) : signed'(mag);
  endfunction : pct_quant

  function automatic logic pct_ok(input logic [cmpset_pkg::VAL_W-1:0] a);
    logic signed [cmpset_pkg::PCT_W-1:0] p;
    p = signed'(a[cmpset_pkg::PCT_W-1:0]);
    pct_ok = (p <= cmpset_pkg::PCT_MAX) && (p >= -cmpset_pkg::PCT_MAX);
  endfunction : pct_ok

  function automatic logic flag_ok(input logic [cmpset_pkg::VAL_W-1:0] a);
    flag_ok = a[cmpset_pkg::VAL_W-1:1] == '0;
  endfunction : flag_ok

  cmpset_judge u_judge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_cfg     (st.cfg),
    .i_meas    (i_meas),
    .o_result  (result)
  );

  // remote commands win; a panel key in the same cycle is dropped
  always_comb begin
    act_remote = i_cmd.valid;
    if (i_cmd.valid) begin
      act = i_cmd;
    end else if (i_key.valid && !st.panel_lock && !i_key.query) begin
      act = i_key;
    end else begin
      act = '0;
    end
  end

  always_comb begin
    next_st = st;
    next_st.resp = '0;
    next_st.range_keep = 1'b0;
    next_st.cal_go = 1'b0;
    if (act.valid) begin
      next_st.resp.valid = act_remote;
      next_st.resp.op = act.op;
      case (act.op)
        cmpset_pkg::OP_COMP_EN: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.cfg.enable);
          end else if (flag_ok(act.arg_a)) begin
            next_st.cfg.enable = act.arg_a[0];
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_BEEP: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.beep);
          end else if (act.arg_a <= cmpset_pkg::VAL_W'(cmpset_pkg::BEEP_ABOVE_OR_BELOW)) begin
            next_st.beep = cmpset_pkg::cmpset_beep_t'(act.arg_a[2:0]);
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_MODE: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.cfg.mode);
          end else if (flag_ok(act.arg_a)) begin
            next_st.cfg.mode = cmpset_pkg::cmpset_mode_t'(act.arg_a[0]);
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_ABS: begin
          if (act.query) begin
            next_st.resp.data_a = st.cfg.upper;
            next_st.resp.data_b = st.cfg.lower;
          end else if (act.arg_a <= cmpset_pkg::RES_MAX && act.arg_b <= cmpset_pkg::RES_MAX) begin
            next_st.cfg.upper = act.arg_a;
            next_st.cfg.lower = act.arg_b;
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_REF: begin
          if (act.query) begin
            next_st.resp.data_a = st.cfg.ref_val;
          end else if (act.arg_a <= cmpset_pkg::RES_MAX) begin
            next_st.cfg.ref_val = act.arg_a;
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_PERC: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.cfg.pct_up);
            next_st.resp.data_b = cmpset_pkg::VAL_W'(st.cfg.pct_lo);
          end else if (pct_ok(act.arg_a) && pct_ok(act.arg_b)) begin
            next_st.cfg.pct_up = pct_quant(act.arg_a[cmpset_pkg::PCT_W-1:0]);
            next_st.cfg.pct_lo = pct_quant(act.arg_b[cmpset_pkg::PCT_W-1:0]);
            next_st.range_keep = 1'b1;
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_RESULT: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(result);
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_CAL: begin
          if (act.query) begin
            next_st.resp.err = 1'b1;
          end else begin
            next_st.cal_pend = 1'b1;
          end
        end
        cmpset_pkg::OP_CAL_AUTO: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.cal_auto);
          end else if (flag_ok(act.arg_a)) begin
            next_st.cal_auto = act.arg_a[0];
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_PANEL_LOCK: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.panel_lock);
          end else if (flag_ok(act.arg_a)) begin
            next_st.panel_lock = act.arg_a[0];
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_HEADER: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.header);
          end else if (flag_ok(act.arg_a)) begin
            next_st.header = act.arg_a[0];
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_GEN_RESET: begin
          if (act.query) begin
            next_st.resp.err = 1'b1;
          end else begin
            next_st.cfg = CFG_RST;
            next_st.beep = cmpset_pkg::BEEP_OFF;
            next_st.header = 1'b0;
            next_st.done_mode = cmpset_pkg::DONE_HOLD;
            next_st.done_width = cmpset_pkg::WIDTH_RST;
          end
        end
        cmpset_pkg::OP_DONE_MODE: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.done_mode);
          end else if (flag_ok(act.arg_a)) begin
            next_st.done_mode = cmpset_pkg::cmpset_done_t'(act.arg_a[0]);
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        cmpset_pkg::OP_DONE_WIDTH: begin
          if (act.query) begin
            next_st.resp.data_a = cmpset_pkg::VAL_W'(st.done_width);
          end else if (act.arg_a >= cmpset_pkg::VAL_W'(cmpset_pkg::WIDTH_MIN)
                       && act.arg_a <= cmpset_pkg::VAL_W'(cmpset_pkg::WIDTH_MAX)) begin
            next_st.done_width = act.arg_a[cmpset_pkg::WIDTH_W-1:0];
          end else begin
            next_st.resp.err = 1'b1;
          end
        end
        default: begin
          next_st.resp.err = 1'b1;
        end
      endcase
    end

    // measurement tracking and calibration that waits for the running one
    if (i_meas.start) begin
      next_st.measuring = 1'b1;
    end
    if (i_meas.done) begin
      next_st.measuring = 1'b0;
    end
    if (st.cal_pend && !st.measuring && !i_meas.start) begin
      next_st.cal_go = 1'b1;
      next_st.cal_pend = act.valid && act.op == cmpset_pkg::OP_CAL && !act.query;
    end

    // end-of-measurement output; completion wins over a release in the same cycle
    if (st.end_of_measurement_out && st.done_mode == cmpset_pkg::DONE_HOLD && i_meas.start) begin
      next_st.end_of_measurement_out = 1'b0;
    end
    if (st.end_of_measurement_out && st.done_mode == cmpset_pkg::DONE_PULSE) begin
      if (st.eom_cnt == '0) begin
        next_st.end_of_measurement_out = 1'b0;
      end else begin
        next_st.eom_cnt = st.eom_cnt - 1'b1;
      end
    end
    if (i_meas.done) begin
      next_st.end_of_measurement_out = 1'b1;
      next_st.eom_cnt = cmpset_pkg::EOM_CNT_W'(st.done_width * P_CYC_PER_MS - 1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '{
        cfg:        CFG_RST,
        beep:       cmpset_pkg::BEEP_OFF,
        cal_auto:   1'b1,
        panel_lock: 1'b0,
        header:     1'b0,
        done_mode:  cmpset_pkg::DONE_HOLD,
        done_width: cmpset_pkg::WIDTH_RST,
        measuring:  1'b0,
        cal_pend:   1'b0,
        cal_go:     1'b0,
        end_of_measurement_out:        1'b0,
        eom_cnt:    '0,
        range_keep: 1'b0,
        resp:       '0
      };
    end else begin
      st <= next_st;
    end
  end

  assign o_cmd_ready = 1'b1;
  assign o_resp = st.resp;
  assign o_range_keep = st.range_keep;
  assign o_cal_start = st.cal_go;
  assign o_cal_auto = st.cal_auto;
  assign o_panel_locked = st.panel_lock;
  assign o_header_on = st.header;
  assign o_beep_sel = st.beep;
  assign o_cfg = st.cfg;
  assign o_end_of_measurement_out = st.end_of_measurement_out;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_range_keep;
    i_cmd.valid && !i_cmd.query && i_cmd.op == cmpset_pkg::OP_REF && i_cmd.arg_a <= cmpset_pkg::RES_MAX
      |=> o_range_keep && o_cfg.ref_val == $past(i_cmd.arg_a);
  endproperty
  a_range_keep: assert property (p_range_keep) else $error("reference write not taken");

  property p_beep_query;
    i_cmd.valid && i_cmd.query && i_cmd.op == cmpset_pkg::OP_BEEP
      |=> o_resp.valid && o_resp.data_a == cmpset_pkg::VAL_W'(o_beep_sel);
  endproperty
  a_beep_query: assert property (p_beep_query) else $error("beeper query mismatch");

  property p_limits_range;
    o_cfg.upper <= cmpset_pkg::RES_MAX && o_cfg.lower <= cmpset_pkg::RES_MAX;
  endproperty
  a_limits_range: assert property (p_limits_range) else $error("limit beyond maximum held");

  property p_lower_reject;
    i_cmd.valid && !i_cmd.query && i_cmd.op == cmpset_pkg::OP_ABS && i_cmd.arg_b > cmpset_pkg::RES_MAX
      |=> o_resp.err && $stable(o_cfg.lower);
  endproperty
  a_lower_reject: assert property (p_lower_reject) else $error("oversized lower limit accepted");

  property p_pct_quant;
    (o_cfg.pct_up >= signed'(cmpset_pkg::PCT_COARSE) || o_cfg.pct_up <= -signed'(cmpset_pkg::PCT_COARSE))
      |-> (o_cfg.pct_up % signed'(cmpset_pkg::PCT_STEP)) == 0;
  endproperty
  a_pct_quant: assert property (p_pct_quant) else $error("coarse percentage not on step");

  property p_cal_wait;
    o_cal_start |-> !$past(st.measuring);
  endproperty
  a_cal_wait: assert property (p_cal_wait) else $error("calibration started mid measurement");

  property p_lock;
    st.panel_lock && !i_cmd.valid |=> $stable(o_cfg) && $stable(o_beep_sel);
  endproperty
  a_lock: assert property (p_lock) else $error("locked panel key changed a setting");

  property p_header_clear;
    i_cmd.valid && !i_cmd.query && i_cmd.op == cmpset_pkg::OP_GEN_RESET |=> !o_header_on;
  endproperty
  a_header_clear: assert property (p_header_clear) else $error("header survived general reset");

  property p_eom_set;
    i_meas.done |=> o_end_of_measurement_out;
  endproperty
  a_eom_set: assert property (p_eom_set) else $error("end of measurement not asserted");

  property p_eom_hold;
    o_end_of_measurement_out && st.done_mode == cmpset_pkg::DONE_HOLD && !i_meas.start && !i_meas.done
      |=> o_end_of_measurement_out;
  endproperty
  a_eom_hold: assert property (p_eom_hold) else $error("hold output released without trigger");

  property p_eom_pulse;
    o_end_of_measurement_out && st.done_mode == cmpset_pkg::DONE_PULSE && st.eom_cnt == '0 && !i_meas.done
      |=> !o_end_of_measurement_out;
  endproperty
  a_eom_pulse: assert property (p_eom_pulse) else $error("pulse output not released");

  property p_width_range;
    i_cmd.valid && !i_cmd.query && i_cmd.op == cmpset_pkg::OP_DONE_WIDTH
      && (i_cmd.arg_a < cmpset_pkg::VAL_W'(cmpset_pkg::WIDTH_MIN)
          || i_cmd.arg_a > cmpset_pkg::VAL_W'(cmpset_pkg::WIDTH_MAX))
      |=> o_resp.err && $stable(st.done_width);
  endproperty
  a_width_range: assert property (p_width_range) else $error("out-of-range pulse width accepted");

  c_pct_write: cover property (i_cmd.valid && i_cmd.op == cmpset_pkg::OP_PERC && !i_cmd.query);
  c_cal_deferred: cover property (st.cal_pend && st.measuring ##[1:50] o_cal_start);
  c_pulse_end: cover property (o_end_of_measurement_out && st.done_mode == cmpset_pkg::DONE_PULSE
                               ##1 !o_end_of_measurement_out);

endmodule : cmpset_handler

/* File: sim/cmpset_host.sv */
/* host model: issues remote commands and keeps the last reply
   assumes the handler takes every command and answers one cycle later */
`timescale 1ns/1ps
module cmpset_host (
  input  wire cmpset_pkg::cmpset_resp_t i_resp,
  input  wire logic                     i_clk,
  output cmpset_pkg::cmpset_cmd_t       o_cmd
);
  cmpset_pkg::cmpset_resp_t last;
  initial o_cmd = '0;
  // launched off the sampling edge one idle cycle after the last, reply read while it stands
  task automatic send(input logic [3:0] op, input logic q, input logic [47:0] a, input logic [47:0] b);
    @(negedge i_clk);
    o_cmd = {1'b1, cmpset_pkg::cmpset_op_t'(op), q, a, b};
    @(negedge i_clk);
    last = i_resp;
    o_cmd = '0;
  endtask : send
endmodule : cmpset_host

/* File: sim/tb_cmpset_handler.sv */
/* bench for the comparator setup handler
   assumes the host model is compiled first */
`timescale 1ns/1ps
module tb_cmpset_handler;
  logic                     i_clk = 0;
  logic                     i_sys_rst = 1;
  cmpset_pkg::cmpset_cmd_t  i_key = '0;
  cmpset_pkg::cmpset_meas_t i_meas = '0;
  cmpset_pkg::cmpset_cmd_t  cmd;
  cmpset_pkg::cmpset_resp_t resp;
  cmpset_pkg::cmpset_cfg_t  cfg;
  cmpset_pkg::cmpset_beep_t beep;
  logic                     rk, cs, ca, pl, hd, end_of_measurement_out, rdy;
  int                       num_errors = 0, checks = 0, n;
  always #4 i_clk = ~i_clk;
  cmpset_host host (.i_resp(resp), .i_clk(i_clk), .o_cmd(cmd));
  cmpset_handler #(.P_CYC_PER_MS(4)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd(cmd), .i_key(i_key),
    .i_meas(i_meas), .o_cmd_ready(rdy), .o_resp(resp), .o_range_keep(rk), .o_cal_start(cs), .o_cal_auto(ca),
    .o_panel_locked(pl), .o_header_on(hd), .o_beep_sel(beep), .o_cfg(cfg), .o_end_of_measurement_out(end_of_measurement_out));
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic meas(input logic st, input logic dn, input logic f, input logic [47:0] v);
    i_meas = {st, dn, f, v};
    @(negedge i_clk);
    i_meas = '0;
  endtask : meas
  task automatic t_set;
    chk(hd, 1'b0);
    chk(ca, 1'b1);
    chk(rdy, 1'b1);
    host.send(4'h9, 1'b0, 48'h0, 48'h0);
    chk(ca, 1'b0);
    host.send(4'h9, 1'b0, 48'h1, 48'h0);
    chk(ca, 1'b1);
    for (int i = 0; i < 6; i++) begin
      host.send(4'h2, 1'b0, 48'(i), 48'h0);
      chk(host.last.err, i == 5);
      host.send(4'h2, 1'b1, 48'h0, 48'h0);
      chk(host.last.data_a, 48'(i == 5 ? 4 : i));
    end
    host.send(4'ha, 1'b0, 48'h1, 48'h0);
    chk(pl, 1'b1);
    i_key = {1'b1, cmpset_pkg::OP_BEEP, 1'b0, 48'h1, 48'h0};
    @(negedge i_clk);
    i_key.valid = 1'b0;
    @(negedge i_clk);
    chk(beep, 3'h4);
    host.send(4'hb, 1'b0, 48'h1, 48'h0);
    chk(hd, 1'b1);
    host.send(4'hc, 1'b0, 48'h0, 48'h0);
    chk(hd, 1'b0);
    $display("t_set done");
  endtask : t_set
  task automatic t_abs;
    logic [47:0] v[4] = '{48'hbb8, 48'h5dc, 48'h64, 48'h5dc};
    host.send(4'h4, 1'b0, cmpset_pkg::RES_MAX, 48'h3e8);
    chk(rk, 1'b1);
    host.send(4'h4, 1'b0, 48'h7d0, cmpset_pkg::RES_MAX + 48'h1);
    chk(host.last.err, 1'b1);
    host.send(4'h4, 1'b1, 48'h0, 48'h0);
    chk(host.last.data_a, cmpset_pkg::RES_MAX);
    chk(host.last.data_b, 48'h3e8);
    host.send(4'h7, 1'b1, 48'h0, 48'h0);
    chk(host.last.data_a, 48'h4);
    host.send(4'h4, 1'b0, 48'h7d0, 48'h3e8);
    host.send(4'h1, 1'b0, 48'h1, 48'h0);
    // above, in, below, then a faulted reading
    for (int i = 0; i < 4; i++) begin
      meas(1'b0, 1'b1, i == 3, v[i]);
      host.send(4'h7, 1'b1, 48'h0, 48'h0);
      chk(host.last.data_a, 48'(i));
    end
    $display("t_abs done");
  endtask : t_abs
  task automatic t_perc;
    host.send(4'h3, 1'b0, 48'h1, 48'h0);
    chk(cfg.mode, 1'b1);
    host.send(4'h5, 1'b0, 48'h3e8, 48'h0);
    host.send(4'h5, 1'b1, 48'h0, 48'h0);
    chk(host.last.data_a, 48'h3e8);
    host.send(4'h6, 1'b0, 48'h3039, 48'hffff_ffff_fa1f);
    chk(cfg.pct_up, 48'h3034);
    chk(48'(cfg.pct_lo), 48'hffff_ffff_fa1f);
    host.send(4'h6, 1'b0, 48'h18697, 48'h0);
    chk(host.last.err, 1'b1);
    meas(1'b0, 1'b1, 1'b0, 48'h3f2);
    host.send(4'h7, 1'b1, 48'h0, 48'h0);
    chk(host.last.data_a, 48'h1);
    meas(1'b0, 1'b1, 1'b0, 48'h3ca);
    host.send(4'h7, 1'b1, 48'h0, 48'h0);
    chk(host.last.data_a, 48'h2);
    $display("t_perc done");
  endtask : t_perc
  task automatic t_eom;
    host.send(4'he, 1'b0, 48'h0, 48'h0);
    chk(host.last.err, 1'b1);
    host.send(4'he, 1'b0, 48'h65, 48'h0);
    chk(host.last.err, 1'b1);
    host.send(4'hd, 1'b0, 48'h1, 48'h0);
    host.send(4'he, 1'b0, 48'h1, 48'h0);
    meas(1'b0, 1'b1, 1'b0, 48'h0);
    n = 0;
    while (end_of_measurement_out === 1'b1 && n < 50) begin
      n++;
      @(negedge i_clk);
    end
    // one ms at four cycles per ms
    chk(48'(n), 48'h4);
    host.send(4'hd, 1'b0, 48'h0, 48'h0);
    meas(1'b0, 1'b1, 1'b0, 48'h0);
    repeat (8) @(negedge i_clk);
    chk(end_of_measurement_out, 1'b1);
    meas(1'b1, 1'b0, 1'b0, 48'h0);
    chk(end_of_measurement_out, 1'b0);
    host.send(4'h8, 1'b0, 48'h0, 48'h0);
    n = 0;
    repeat (6) @(negedge i_clk) n += cs;
    chk(48'(n), 48'h0);
    meas(1'b0, 1'b1, 1'b0, 48'h0);
    repeat (4) @(negedge i_clk) n += cs;
    chk(48'(n), 48'h1);
    $display("t_eom done");
  endtask : t_eom
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_set;
    t_abs;
    t_perc;
    t_eom;
    tally_and_finish;
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge i_clk);
    num_errors++;
    tally_and_finish;
  end
endmodule : tb_cmpset_handler
